//--- rtl/ccr_pkg.sv
// Purpose: Shared constants and types for the comparator control register block
// Assumes: Core special-function bus with 8-bit address, page and data, one clock
// Notes: Every offset, field position and reset value is named once here
package ccr_pkg;

  // Special-function address and the pages on which the register is visible
  localparam logic [7:0] CCR_ADDR_CONTROL = 8'hbf;
  localparam logic [7:0] CCR_PAGE_LOW = 8'h00;
  localparam logic [7:0] CCR_PAGE_HIGH = 8'h30;

  // Field positions inside comparator1_control_zero
  localparam int CCR_BIT_ON = 7;
  localparam int CCR_BIT_RESULT = 6;
  localparam int CCR_BIT_RISE = 5;
  localparam int CCR_BIT_FALL = 4;
  localparam int CCR_UPPER_HI = 3;
  localparam int CCR_UPPER_LO = 2;
  localparam int CCR_LOWER_HI = 1;
  localparam int CCR_LOWER_LO = 0;

  // Reset values
  localparam logic CCR_RST_ON = 1'b0;
  localparam logic CCR_RST_RESULT = 1'b0;
  localparam logic CCR_RST_RISE = 1'b0;
  localparam logic CCR_RST_FALL = 1'b0;
  localparam logic [1:0] CCR_RST_HYST = 2'h0;
  localparam logic [7:0] CCR_RST_RDATA = 8'h00;

  // Hysteresis codes
  localparam logic [1:0] CCR_HYST_OFF = 2'h0;
  localparam logic [1:0] CCR_HYST_LEVEL1 = 2'h1;
  localparam logic [1:0] CCR_HYST_LEVEL2 = 2'h2;
  localparam logic [1:0] CCR_HYST_MAX = 2'h3;

  // Synchroniser depth for the asynchronous comparator output
  localparam int CCR_SYNC_STAGES = 2;

  // One access from the core on the special-function bus
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] page;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } ccr_sfr_req_t;

  // Answer to the core
  typedef struct packed {
    logic hit;
    logic [7:0] rdata;
  } ccr_sfr_rsp_t;

  // Settings that steer the analog comparator
  typedef struct packed {
    logic comparator_on;
    logic [1:0] upper_hysteresis_sel;
    logic [1:0] lower_hysteresis_sel;
  } ccr_analog_ctl_t;

endpackage : ccr_pkg

//--- rtl/ccr_sync.sv
// Purpose: Two-flop synchroniser for the asynchronous comparator decision
// Assumes: Input changes slowly compared with the clock
// Notes: First stage is read only by the second stage
`timescale 1ns/100ps
`default_nettype none
module ccr_sync
  import ccr_pkg::*;
#(
  parameter int STAGES = CCR_SYNC_STAGES
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic async_in,
  output logic sync_out
);

  logic [STAGES-1:0] stage_reg;
  logic [STAGES-1:0] stage_next;

  always_comb begin
    stage_next = {stage_reg[STAGES-2:0], async_in};
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      stage_reg <= '0;
    end else begin
      stage_reg <= stage_next;
    end
  end

  assign sync_out = stage_reg[STAGES-1];

endmodule : ccr_sync
`default_nettype wire

//--- rtl/ccr_control.sv
// Purpose: Control and status register of the second analog comparator
// Assumes: Core bus on the system clock; comparator decision arrives asynchronously
// Notes: Read data are registered and appear one cycle after the read strobe
`timescale 1ns/100ps
`default_nettype none

module ccr_control
  import ccr_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire ccr_sfr_req_t sfr_req,
  output ccr_sfr_rsp_t sfr_rsp,
  input wire logic positive_above_negative,
  output ccr_analog_ctl_t analog_ctl,
  output logic rise_seen_flag,
  output logic fall_seen_flag,
  output logic compare_result
);

  // Address decode
  logic sel;
  logic wr_hit;
  logic rd_hit;

  always_comb begin
    sel = (sfr_req.addr == CCR_ADDR_CONTROL) &&
          ((sfr_req.page == CCR_PAGE_LOW) || (sfr_req.page == CCR_PAGE_HIGH));
    wr_hit = sel && sfr_req.wr;
    rd_hit = sel && sfr_req.rd;
  end

  // Synchronised comparator decision
  logic decision_sync;

  ccr_sync #(
    .STAGES(CCR_SYNC_STAGES)
  ) u_sync (
    .clock(clock),
    .rstn(rstn),
    .async_in(positive_above_negative),
    .sync_out(decision_sync)
  );

  // Control fields written by software
  logic on_reg;
  logic on_next;
  logic [1:0] upper_reg;
  logic [1:0] upper_next;
  logic [1:0] lower_reg;
  logic [1:0] lower_next;

  always_comb begin
    on_next = on_reg;
    upper_next = upper_reg;
    lower_next = lower_reg;
    if (wr_hit) begin
      on_next = sfr_req.wdata[CCR_BIT_ON];
      upper_next = sfr_req.wdata[CCR_UPPER_HI:CCR_UPPER_LO];
      lower_next = sfr_req.wdata[CCR_LOWER_HI:CCR_LOWER_LO];
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      on_reg <= CCR_RST_ON;
      upper_reg <= CCR_RST_HYST;
      lower_reg <= CCR_RST_HYST;
    end else begin
      on_reg <= on_next;
      upper_reg <= upper_next;
      lower_reg <= lower_next;
    end
  end

  // Result tracking
  // A disabled comparator gives no valid decision, so the result reads zero
  logic result_reg;
  logic result_next;
  logic armed_reg;
  logic armed_next;

  always_comb begin
    result_next = on_reg ? decision_sync : CCR_RST_RESULT;
    // Edges only count once a valid result has been sampled while enabled
    armed_next = on_reg;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      result_reg <= CCR_RST_RESULT;
      armed_reg <= 1'b0;
    end else begin
      result_reg <= result_next;
      armed_reg <= armed_next;
    end
  end

  // Edge events
  logic rise_event;
  logic fall_event;

  always_comb begin
    rise_event = armed_reg && on_reg && !result_reg && result_next;
    fall_event = armed_reg && on_reg && result_reg && !result_next;
  end

  // Sticky event flags
  // Hardware never clears them; a set in the cycle of a clearing write wins
  logic rise_reg;
  logic rise_next;
  logic fall_reg;
  logic fall_next;

  always_comb begin
    rise_next = rise_reg;
    fall_next = fall_reg;
    if (wr_hit) begin
      rise_next = sfr_req.wdata[CCR_BIT_RISE];
      fall_next = sfr_req.wdata[CCR_BIT_FALL];
    end
    if (rise_event) begin
      rise_next = 1'b1;
    end
    if (fall_event) begin
      fall_next = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rise_reg <= CCR_RST_RISE;
      fall_reg <= CCR_RST_FALL;
    end else begin
      rise_reg <= rise_next;
      fall_reg <= fall_next;
    end
  end

  // Register image as software sees it
  logic [7:0] image;

  always_comb begin
    image = 8'h00;
    image[CCR_BIT_ON] = on_reg;
    image[CCR_BIT_RESULT] = result_reg;
    image[CCR_BIT_RISE] = rise_reg;
    image[CCR_BIT_FALL] = fall_reg;
    image[CCR_UPPER_HI:CCR_UPPER_LO] = upper_reg;
    image[CCR_LOWER_HI:CCR_LOWER_LO] = lower_reg;
  end

  // Read path
  // Read data are held between reads so a slow core may sample late
  logic hit_reg;
  logic hit_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  always_comb begin
    hit_next = rd_hit;
    rdata_next = rdata_reg;
    if (rd_hit) begin
      rdata_next = image;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      hit_reg <= 1'b0;
      rdata_reg <= CCR_RST_RDATA;
    end else begin
      hit_reg <= hit_next;
      rdata_reg <= rdata_next;
    end
  end

  // Outputs, all straight from flip-flops
  always_comb begin
    sfr_rsp.hit = hit_reg;
    sfr_rsp.rdata = rdata_reg;
    analog_ctl.comparator_on = on_reg;
    analog_ctl.upper_hysteresis_sel = upper_reg;
    analog_ctl.lower_hysteresis_sel = lower_reg;
    rise_seen_flag = rise_reg;
    fall_seen_flag = fall_reg;
    compare_result = result_reg;
  end

endmodule : ccr_control
`default_nettype wire

//--- sim/ccr_control_sva.sv
// Purpose: Port assertions for the comparator control register
// Assumes: One clock, asynchronous active-low reset
// Notes: Bound to every ccr_control instance
`timescale 1ns/100ps
`default_nettype none
module ccr_control_sva
  import ccr_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire ccr_sfr_req_t sfr_req,
  input wire ccr_sfr_rsp_t sfr_rsp,
  input wire logic positive_above_negative,
  input wire ccr_analog_ctl_t analog_ctl,
  input wire logic rise_seen_flag,
  input wire logic fall_seen_flag,
  input wire logic compare_result
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  wire logic sel;
  wire logic wsel;
  assign sel = sfr_req.addr == CCR_ADDR_CONTROL
    && (sfr_req.page == CCR_PAGE_LOW || sfr_req.page == CCR_PAGE_HIGH);
  assign wsel = sel && sfr_req.wr;
  property p_hit; sfr_req.rd && sel |=> sfr_rsp.hit; endproperty
  a_hit: assert property (p_hit) else $error("no hit");
  property p_miss; !(sfr_req.rd && sel) |=> !sfr_rsp.hit; endproperty
  a_miss: assert property (p_miss) else $error("stray hit");
  property p_res; sfr_req.rd && sel |=> sfr_rsp.rdata[6] == $past(compare_result); endproperty
  a_res: assert property (p_res) else $error("bad result bit");
  property p_rise; rise_seen_flag && !wsel |=> rise_seen_flag; endproperty
  a_rise: assert property (p_rise) else $error("rise flag lost");
  property p_fall; fall_seen_flag && !wsel |=> fall_seen_flag; endproperty
  a_fall: assert property (p_fall) else $error("fall flag lost");
  property p_up; wsel |=> analog_ctl.upper_hysteresis_sel == $past(sfr_req.wdata[3:2]); endproperty
  a_up: assert property (p_up) else $error("bad upper sel");
  property p_lo; wsel |=> analog_ctl.lower_hysteresis_sel == $past(sfr_req.wdata[1:0]); endproperty
  a_lo: assert property (p_lo) else $error("bad lower sel");
  property p_on; wsel |=> analog_ctl.comparator_on == $past(sfr_req.wdata[7]); endproperty
  a_on: assert property (p_on) else $error("bad enable");
endmodule : ccr_control_sva
bind ccr_control ccr_control_sva ccr_control_sva_inst (.clock, .rstn, .sfr_req, .sfr_rsp,
  .positive_above_negative, .analog_ctl, .rise_seen_flag, .fall_seen_flag, .compare_result);
`default_nettype wire

//--- sim/tb_ccr_control.sv
// Purpose: Self-checking bench for the comparator control register
// Assumes: Inputs driven by non-blocking assignment at rising edges
// Notes: Result bit settles three cycles after the analog input moves
`timescale 1ns/100ps
`default_nettype none
module tb_ccr_control
  import ccr_pkg::*;
;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  ccr_sfr_req_t req = '0;
  ccr_sfr_rsp_t rsp;
  ccr_analog_ctl_t ctl;
  logic pan = 1'b0;
  logic res;
  logic rise;
  logic fall;
  int fails = 0;
  int total_checks = 0;
  int cyc = 0;
  ccr_control ccr_control_inst (.clock(clock), .rstn(rstn), .sfr_req(req), .sfr_rsp(rsp),
    .positive_above_negative(pan), .analog_ctl(ctl), .rise_seen_flag(rise),
    .fall_seen_flag(fall), .compare_result(res));
  always #20 clock = ~clock;
  task wrap_up;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      wrap_up();
    end
  end
  task chk(input string n, input logic [7:0] e, input logic [7:0] s);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s exp %h got %h", n, e, s);
    end
  endtask : chk
  // Every access checks hit; a missed read expects the held data
  task acc(input logic w, input logic [7:0] pg, ad, wd, e, input logic h);
    @(posedge clock);
    req <= '{ad, pg, w, !w, wd};
    @(posedge clock);
    req <= '{ad, pg, 1'b0, 1'b0, wd};
    @(negedge clock);
    chk("hit", {7'h0, h}, {7'h0, rsp.hit});
    if (!w) chk("rdata", e, rsp.rdata);
  endtask : acc
  task t_reset;
    chk("ctl", 8'h00, {3'h0, ctl});
    chk("flags", 8'h00, {5'h0, res, rise, fall});
    acc(1'b0, 8'h00, 8'hbf, 8'h00, 8'h00, 1'b1);
    $display("reset done");
  endtask : t_reset
  task t_fields;
    for (int i = 0; i < 4; i++) begin
      acc(1'b1, 8'h30, 8'hbf, {4'h8, i[1:0], ~i[1:0]}, 8'h00, 1'b0);
      chk("ctl", {4'h1, i[1:0], ~i[1:0]}, {3'h0, ctl});
      acc(1'b0, 8'h00, 8'hbf, 8'h00, {4'h8, i[1:0], ~i[1:0]}, 1'b1);
    end
    $display("fields done");
  endtask : t_fields
  task t_edges;
    acc(1'b1, 8'h00, 8'hbf, 8'h80, 8'h00, 1'b0);
    @(posedge clock);
    pan <= 1'b1;
    repeat (2) @(posedge clock);
    @(negedge clock);
    chk("early rise", 8'h00, {5'h0, res, rise, fall});
    @(negedge clock);
    chk("rise ports", 8'h06, {5'h0, res, rise, fall});
    repeat (2) @(posedge clock);
    acc(1'b0, 8'h00, 8'hbf, 8'h00, 8'he0, 1'b1);
    acc(1'b1, 8'h00, 8'hbf, 8'h80, 8'h00, 1'b0);
    acc(1'b0, 8'h30, 8'hbf, 8'h00, 8'hc0, 1'b1);
    @(posedge clock);
    pan <= 1'b0;
    repeat (2) @(posedge clock);
    @(negedge clock);
    chk("early fall", 8'h04, {5'h0, res, rise, fall});
    @(negedge clock);
    chk("fall ports", 8'h01, {5'h0, res, rise, fall});
    repeat (2) @(posedge clock);
    acc(1'b0, 8'h00, 8'hbf, 8'h00, 8'h90, 1'b1);
    acc(1'b1, 8'h00, 8'hbf, 8'hc0, 8'h00, 1'b0);
    acc(1'b0, 8'h00, 8'hbf, 8'h00, 8'h80, 1'b1);
    $display("edges done");
  endtask : t_edges
  task t_miss;
    acc(1'b1, 8'h00, 8'hbe, 8'h0f, 8'h00, 1'b0);
    acc(1'b1, 8'h10, 8'hbf, 8'h0f, 8'h00, 1'b0);
    acc(1'b0, 8'h10, 8'hbf, 8'h00, 8'h80, 1'b0);
    acc(1'b0, 8'h00, 8'hbf, 8'h00, 8'h80, 1'b1);
    $display("miss done");
  endtask : t_miss
  initial begin
    repeat (16) @(posedge clock);
    rstn <= 1'b1;
    t_reset();
    t_fields();
    t_edges();
    t_miss();
    wrap_up();
  end
endmodule : tb_ccr_control
`default_nettype wire
